// *** hw/crlc_top.sv ***
// comparator reference ladder control with its avalon-mm register slave
// Overview of operation
// R1 - device reset clears ladder power enable, ladder off
// R2 - reset also clears pin output enable, range select and tap bits
// R3 - bit 7 powers the ladder on when one, down when zero
// R4 - bit 6 routes level to pin, overriding that pin's direction bit
// R5 - bit 5 one picks low range, zero picks high range
// R6 - bit 4 one uses external reference pins, zero uses supply rails
// R7 - bits 3 to 0 hold tap value 0 to 15
// R8 - level is tap/24 low range, 1/4 plus tap/32 high range
// R9 - wake from sleep leaves the control register unchanged
// R10 - reference controls work independent of comparator mode
// R11 - software should clear ladder enable before sleep
// R12 - reference reaches comparator inputs only in four-to-two mode
// R13 - write updates all eight bits next edge, read returns them
`timescale 1ns/1ps
module crlc_top
  import crlc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic avs_readdatavalid_o,
  output crlc_pkg::crlc_analog_t analog_o,
  output logic [7:0] ctrl_o
);

  import crlc_pkg::*;

  crlc_ctrl_t ctrl_q;
  logic [3:0] env_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic rvalid_q;
  logic [6:0] level;
  logic pin_route_q;
  logic pin_dir_out_q;
  logic cmp_ref_q;
  logic access;
  logic wr_hit;

  // one wait cycle on every access so read data come from a register
  assign access = (avs_read_i || avs_write_i) && !ack_q;
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_q;
  assign wr_hit = avs_write_i && ack_q;

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ack_q <= 1'b0;
    end
    else
    begin
      ack_q <= access;
    end
  end

  // only reset and bus writes change it; there is no sleep input, so wake cannot disturb it
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ctrl_q <= CRLC_CONTROL_RST; // R1 R2 R9
    end
    else if (wr_hit && avs_address_i == CRLC_OFS_CONTROL && avs_byteenable_i[0])
    begin
      ctrl_q <= avs_writedata_i[7:0]; // R13
    end
  end

  // comparator mode and pin direction mirrored here by software
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      env_q <= CRLC_ENV_RST;
    end
    else if (wr_hit && avs_address_i == CRLC_OFS_ENV && avs_byteenable_i[0])
    begin
      env_q <= avs_writedata_i[3:0];
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rdata_q <= CRLC_UNMAPPED_DATA;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rvalid_q <= avs_read_i && ack_q;
      if (avs_read_i && !ack_q)
      begin
        case (avs_address_i)
          CRLC_OFS_CONTROL: rdata_q <= {24'h000000, ctrl_q}; // R13
          CRLC_OFS_STATUS: rdata_q <= {22'h000000, cmp_ref_q, pin_route_q,
                                       ctrl_q.ladder_power_enable, level};
          CRLC_OFS_ENV: rdata_q <= {28'h0000000, env_q};
          default: rdata_q <= CRLC_UNMAPPED_DATA;
        endcase
      end
    end
  end

  assign avs_readdata_o = rdata_q;
  assign avs_readdatavalid_o = rvalid_q;

  crlc_level_decode u_decode (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .range_low_i(ctrl_q.ref_range_select), // R5
    .tap_i(ctrl_q.ladder_tap_value), // R7
    .level_o(level)
  );

  // pin routing and comparator hookup, registered for clean analog switch control
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pin_route_q <= 1'b0;
      pin_dir_out_q <= 1'b0;
      cmp_ref_q <= 1'b0;
    end
    else
    begin
      pin_route_q <= ctrl_q.ref_pin_output_enable; // R4 R10
      // digital driver held off while routed, whatever the direction bit says
      pin_dir_out_q <= !env_q[CRLC_ENV_DIR_BIT] && !ctrl_q.ref_pin_output_enable; // R4
      cmp_ref_q <= env_q[CRLC_ENV_MODE_MSB:CRLC_ENV_MODE_LSB] == CRLC_MODE_FOUR_TO_TWO; // R12
    end
  end

  always_comb
  begin
    analog_o.ladder_power_enable = ctrl_q.ladder_power_enable; // R3 R10
    analog_o.ladder_source_select = ctrl_q.ladder_source_select; // R6
    analog_o.ladder_output_level = level;
    analog_o.pin_route = pin_route_q;
    analog_o.pin_digital_out_en = pin_dir_out_q;
    analog_o.cmp_ref_select = cmp_ref_q;
  end

  assign ctrl_o = ctrl_q;

endmodule

// *** hw/crlc_pkg.sv ***
// package for the comparator reference ladder control block
package crlc_pkg;

  localparam int unsigned CRLC_ADDR_W = 4;
  localparam int unsigned CRLC_DATA_W = 32;

  // register byte addresses
  localparam logic [3:0] CRLC_OFS_CONTROL = 4'h0;
  localparam logic [3:0] CRLC_OFS_STATUS = 4'h4;
  localparam logic [3:0] CRLC_OFS_ENV = 4'h8;

  // control register fields
  localparam int unsigned CRLC_BIT_POWER = 7;
  localparam int unsigned CRLC_BIT_PIN_OE = 6;
  localparam int unsigned CRLC_BIT_RANGE = 5;
  localparam int unsigned CRLC_BIT_SOURCE = 4;
  localparam int unsigned CRLC_TAP_MSB = 3;
  localparam int unsigned CRLC_TAP_LSB = 0;
  localparam logic [7:0] CRLC_CONTROL_RST = 8'h00;

  // environment register fields
  localparam int unsigned CRLC_ENV_MODE_LSB = 0;
  localparam int unsigned CRLC_ENV_MODE_MSB = 2;
  localparam int unsigned CRLC_ENV_DIR_BIT = 3;
  localparam logic [3:0] CRLC_ENV_RST = 4'hF;

  // comparator mode that routes the ladder to both positive inputs
  localparam logic [2:0] CRLC_MODE_FOUR_TO_TWO = 3'h6;

  // level decode: numerator over a common denominator of 96
  localparam logic [6:0] CRLC_LEVEL_DEN = 7'h60;
  localparam logic [2:0] CRLC_LOW_STEP = 3'h4;
  localparam logic [2:0] CRLC_HIGH_STEP = 3'h3;
  localparam logic [6:0] CRLC_HIGH_BASE = 7'h18;

  localparam logic [31:0] CRLC_UNMAPPED_DATA = 32'h0000_0000;

  typedef struct packed {
    logic ladder_power_enable;
    logic ref_pin_output_enable;
    logic ref_range_select;
    logic ladder_source_select;
    logic [3:0] ladder_tap_value;
  } crlc_ctrl_t;

  typedef struct packed {
    logic ladder_power_enable;
    logic ladder_source_select;
    logic [6:0] ladder_output_level;
    logic pin_route;
    logic pin_digital_out_en;
    logic cmp_ref_select;
  } crlc_analog_t;

endpackage

// *** hw/crlc_level_decode.sv ***
// tap decode into a ladder level expressed in 96ths of source span
`timescale 1ns/1ps
module crlc_level_decode
  import crlc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic range_low_i,
  input wire logic [3:0] tap_i,
  output logic [6:0] level_o
);

  logic [6:0] level_d;
  logic [6:0] level_q;

  // low: tap/24 = 4*tap/96; high: 1/4 + tap/32 = (24 + 3*tap)/96
  always_comb
  begin
    if (range_low_i)
    begin
      level_d = 7'(tap_i) * 7'(CRLC_LOW_STEP); // R8
    end
    else
    begin
      // widened before the product: top tap in high range reaches 69, past 4 bits
      level_d = CRLC_HIGH_BASE + 7'(tap_i) * 7'(CRLC_HIGH_STEP); // R8
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      level_q <= 7'h00;
    end
    else
    begin
      level_q <= level_d;
    end
  end

  assign level_o = level_q;

endmodule

// *** verif/crlc_top_props.sv ***
// assertion checker bound to the ladder control top
`timescale 1ns/1ps
module crlc_top_props (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic avs_waitrequest_o,
  input wire crlc_pkg::crlc_analog_t analog_o,
  input wire logic [7:0] ctrl_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  wire logic wr = avs_write_i && !avs_waitrequest_o && avs_address_i == 4'h0
    && avs_byteenable_i[0];
  wire logic [6:0] lvl = analog_o.ladder_output_level;
  sequence s_one_wait;
    avs_waitrequest_o ##1 !avs_waitrequest_o;
  endsequence
  a_reset_clear:
  assert property ($rose(rstn_i) |-> ctrl_o == 8'h00) else $error("ctrl not cleared");
  a_write_store:
  assert property (wr |=> ctrl_o == $past(avs_writedata_i[7:0])) else $error("write lost");
  a_ctrl_hold:
  assert property (!wr |=> $stable(ctrl_o)) else $error("ctrl changed");
  a_direct_bits:
  assert property (analog_o.ladder_power_enable == ctrl_o[7]
    && analog_o.ladder_source_select == ctrl_o[4]) else $error("bad power or source");
  a_level_low:
  assert property (ctrl_o[5] |=> lvl == {1'b0, $past(ctrl_o[3:0]), 2'b00}) else $error("low lvl");
  a_level_high:
  assert property (!ctrl_o[5] |=> lvl == 7'h18 + {3'h0, $past(ctrl_o[3:0])} * 7'h3)
    else $error("high lvl");
  a_pin_override:
  assert property (analog_o.pin_route |-> !analog_o.pin_digital_out_en) else $error("pin clash");
  a_one_wait:
  assert property ($rose(avs_read_i || avs_write_i) |-> s_one_wait) else $error("wait count");
endmodule
bind crlc_top crlc_top_props u_props (.clk_i, .rstn_i, .avs_address_i, .avs_read_i,
  .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_waitrequest_o, .analog_o, .ctrl_o);

// *** verif/tb_crlc_top.sv ***
// self-checking bench for the ladder control block
`timescale 1ns/1ps
module tb_crlc_top;
  import crlc_pkg::*;
  logic clk_i = 0, rstn_i = 0, avs_read_i = 0, avs_write_i = 0, avs_waitrequest_o;
  logic [3:0] avs_address_i = 4'h0, avs_byteenable_i = 4'hF;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, s = 32'h7043, q[$];
  logic [7:0] ctrl_o, c, edge_v[4] = '{8'hFF, 8'h2F, 8'h0F, 8'hC0};
  logic [2:0] m = 3'h7;
  logic avs_readdatavalid_o, rd_seen = 1'b0, dir = 1'b1;
  logic [19:0] qa[$];
  crlc_analog_t analog_o;
  int n_fail = 0, check_count = 0, cyc = 0;
  crlc_top dut (.clk_i, .rstn_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .avs_readdatavalid_o,
    .analog_o, .ctrl_o);
  initial forever #5 clk_i = ~clk_i;
  function logic [31:0] xs();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // status word: cmp select, pin route, power, level in 96ths
  function logic [31:0] st(input logic [7:0] v);
    logic [6:0] l;
    l = v[5] ? {1'b0, v[3:0], 2'b00} : 7'h18 + {3'h0, v[3:0]} * 7'h3;
    return {22'h0, m == CRLC_MODE_FOUR_TO_TWO, v[6], v[7], l};
  endfunction
  // control byte then analog controls; digital driver only when output and not routed
  function logic [19:0] an(input logic [7:0] v);
    logic [31:0] w;
    w = st(v);
    return {v, v[7], v[4], w[6:0], v[6], !dir && !v[6], m == CRLC_MODE_FOUR_TO_TWO};
  endfunction
  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // a read passes its expected word in d; release only after waitrequest low
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_address_i <= a;
    avs_writedata_i <= d;
    if (!w)
      q.push_back(d);
    do @(posedge clk_i); while (avs_waitrequest_o);
    avs_write_i <= 0;
    avs_read_i <= 0;
  endtask
  task final_report();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    cyc++;
    if (avs_read_i && !avs_waitrequest_o && q.size() > 0)
      chk(avs_readdata_o, q.pop_front());
    if (qa.size() > 0)
      chk({12'h000, ctrl_o, analog_o}, {12'h000, qa.pop_front()});
    if (rstn_i)
      chk({31'h0, avs_readdatavalid_o}, {31'h0, rd_seen});
    rd_seen <= avs_read_i && !avs_waitrequest_o;
    if (cyc > 2000)
    begin
      n_fail++;
      final_report();
    end
  end
  initial
  begin
    repeat (16) @(posedge clk_i);
    rstn_i <= 1;
    bus(0, 4'h0, 32'h0);
    bus(0, 4'h8, 32'hF);
    bus(0, 4'h4, st(8'h00));
    qa.push_back(an(8'h00));
    for (int i = 0; i < 24; i++)
    begin
      if (i == 12)
      begin
        m = 3'h6;
        dir = 1'b0;
        bus(1, 4'h8, 32'h6);
      end
      c = i < 4 ? edge_v[i] : 8'(xs());
      bus(1, 4'h0, {24'(xs()), c});
      bus(0, 4'h0, {24'h0, c});
      bus(0, 4'h4, st(c));
      qa.push_back(an(c));
    end
    avs_byteenable_i <= 4'h0;
    bus(1, 4'h0, 32'h0);
    avs_byteenable_i <= 4'hF;
    bus(0, 4'h0, {24'h0, c});
    bus(1, 4'hC, 32'hFF);
    bus(0, 4'hC, 32'h0);
    bus(1, 4'h4, 32'h0);
    bus(0, 4'h4, st(c));
    // power the ladder down before sleep, other settings kept
    c[7] = 1'b0;
    bus(1, 4'h0, {24'h0, c});
    bus(0, 4'h0, {24'h0, c});
    // reset in mid-run must clear every control bit
    rstn_i <= 0;
    repeat (3) @(posedge clk_i);
    rstn_i <= 1;
    m = 3'h7;
    dir = 1'b1;
    bus(0, 4'h0, 32'h0);
    bus(0, 4'h4, st(8'h00));
    qa.push_back(an(8'h00));
    repeat (3) @(posedge clk_i);
    final_report();
  end
endmodule
